// ### logic/sfs_top.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
// Summary of operation
// (RL1) received word carries chip-select levels at end
// (RL2) chip selects idle high around transfers
// (RL3) master sees slave-select low: mode fault
// (RL4) mode fault bit 2 held until status read
// (RL5) mode fault disables until enable command
// (RL6) slave waits for slave-select low first
// (RL7) slave uses select config zero only
// (RL8) rx full bit 0, cleared reading rx data
// (RL9) tx empty bit 1, write clears, move sets
// (RL10) tx empty zero reset/disabled, enable sets
// (RL11) overrun bit 3, double load, status read clears
// (RL12) bit 4 mirrors rx dma end
// (RL13) bit 5 mirrors tx dma end
// (RL14) bit 16 shows enabled state
// (RL15) select mode picks mode or word select field
// (RL16) decode bit: direct four or decoded fifteen
// (RL17) slave-select input double synchronised

module sfs_fifo #(
  parameter int W = 20,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         clear,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;

  assign in_ready  = (count_r != (AW+1)'(D));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || clear) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

module sfs_top (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic [sfs_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [sfs_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [sfs_pkg::DATA_W-1:0]  reg_rdata,
  output logic                             tx_ready,
  input  wire logic                        rx_dma_end,
  input  wire logic                        tx_dma_end,
  input  wire logic                        spck_in,
  output logic                             spck_out,
  output logic                             spck_oe,
  input  wire logic                        mosi_in,
  output logic                             mosi_out,
  output logic                             mosi_oe,
  input  wire logic                        miso_in,
  output logic                             miso_out,
  output logic                             miso_oe,
  input  wire logic                        slave_select_in_n,
  output logic      [sfs_pkg::PCS_W-1:0]   periph_select_out
);
  typedef enum logic [3:0] {
    SFS_IDLE  = 4'b0001,
    SFS_SETUP = 4'b0010,
    SFS_SHIFT = 4'b0100,
    SFS_END   = 4'b1000
  } sfs_state_type;

  // lowest low line in direct mode, top two bits in decoded mode
  function automatic logic [1:0] csr_index(input logic [3:0] periph_select_field, input logic dec);
    logic [1:0] idx;
    idx = 2'h3;
    if (dec) begin
      idx = periph_select_field[3:2];
    end else begin
      for (int i = 3; i >= 0; i--) begin
        if (!periph_select_field[i]) begin
          idx = 2'(i);
        end
      end
    end
    return idx;
  endfunction

  function automatic logic [3:0] pcs_lines(input logic [3:0] periph_select_field, input logic dec);
    logic [3:0] lines;
    lines = sfs_pkg::PCS_IDLE;
    if (dec) begin
      lines = periph_select_field;
    end else begin
      lines[csr_index(periph_select_field, 1'b0)] = 1'b0;
    end
    return lines;
  endfunction

  function automatic logic [4:0] word_bits(input logic [31:0] csr);
    logic [3:0] f;
    f = csr[sfs_pkg::CSR_BITS_HI:sfs_pkg::CSR_BITS_LO];
    if (f > sfs_pkg::BITS_MAX) begin
      f = sfs_pkg::BITS_MAX;
    end
    return sfs_pkg::BITS_BASE + 5'(f);
  endfunction

  function automatic logic msb_pick(input logic [15:0] sh, input logic [4:0] nbits);
    return sh[4'(nbits - 5'h01)];
  endfunction

  logic [31:0]   mode_r;
  logic [31:0]   csr_r [4];
  logic          enabled_r;
  logic          rx_full_r;
  logic          tx_empty_r;
  logic          mode_fault_flag_r;
  logic          ovr_r;
  logic [19:0]   rx_data_r;
  logic [1:0]    ss_sync_r;
  logic [2:0]    sck_sync_r;
  logic [1:0]    mosi_sync_r;
  logic [1:0]    miso_sync_r;
  logic [7:0]    div_cnt_r;
  logic          tick;
  sfs_state_type state_r;
  logic          sck_r;
  logic [15:0]   tx_sh_r;
  logic [15:0]   rx_sh_r;
  logic [4:0]    bit_cnt_r;
  logic [4:0]    nbits_r;
  logic          clock_polarity_r;
  logic          clock_phase_inv_r;
  logic [3:0]    cs_r;
  logic          slv_loaded_r;
  logic          miso_r;
  logic          is_master;
  logic          ss_low;
  logic          ctl_wr;
  logic          en_cmd;
  logic          dis_cmd;
  logic          sr_rd;
  logic          rdr_rd;
  logic          tdr_wr;
  logic          fifo_valid;
  logic          fifo_pop;
  logic [19:0]   fifo_data;
  logic [3:0]    pop_pcs;
  logic          m_edge;
  logic          m_lead;
  logic          s_edge;
  logic          s_lead;
  logic          sample_ev;
  logic          shift_ev;
  logic          samp_bit;
  logic          word_done;
  logic          mode_fault_flag_ev;

  assign is_master = mode_r[sfs_pkg::MODE_MASTER];
  assign ss_low    = !ss_sync_r[1];
  assign ctl_wr    = reg_wr && (reg_addr == sfs_pkg::OFS_CONTROL);
  assign dis_cmd   = ctl_wr && reg_wdata[sfs_pkg::CTL_DISABLE];
  assign en_cmd    = ctl_wr && reg_wdata[sfs_pkg::CTL_ENABLE] && !dis_cmd;
  assign sr_rd     = reg_rd && (reg_addr == sfs_pkg::OFS_STATUS);
  assign rdr_rd    = reg_rd && (reg_addr == sfs_pkg::OFS_RX_DATA);
  assign tdr_wr    = reg_wr && (reg_addr == sfs_pkg::OFS_TX_DATA) && tx_ready;
  assign mode_fault_flag_ev   = is_master && enabled_r && ss_low;  // see (RL3)

  sfs_fifo #(
    .W(sfs_pkg::FIFO_W),
    .D(sfs_pkg::FIFO_D)
  ) u_tx_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .clear    (dis_cmd || mode_fault_flag_ev),  // flush on shutdown only, so words can queue before enable
    .in_valid (reg_wr && (reg_addr == sfs_pkg::OFS_TX_DATA)),
    .in_ready (tx_ready),
    .in_data  (reg_wdata[sfs_pkg::PCS_HI:0]),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data (fifo_data)
  );

  // pin inputs: only the second stage is looked at, except the serial clock, whose third stage also feeds edge detection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ss_sync_r   <= 2'h3;
      sck_sync_r  <= 3'h0;
      mosi_sync_r <= 2'h0;
      miso_sync_r <= 2'h0;
    end else begin
      ss_sync_r   <= {ss_sync_r[0], slave_select_in_n};  // see (RL17)
      sck_sync_r  <= {sck_sync_r[1:0], spck_in};
      mosi_sync_r <= {mosi_sync_r[0], mosi_in};
      miso_sync_r <= {miso_sync_r[0], miso_in};
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_r <= sfs_pkg::MODE_RESET;
      for (int i = 0; i < 4; i++) begin
        csr_r[i] <= sfs_pkg::CSR_RESET;
      end
    end else if (reg_wr) begin
      if (reg_addr == sfs_pkg::OFS_MODE) begin
        mode_r <= reg_wdata;
      end
      if (reg_addr == sfs_pkg::OFS_CSR0) begin
        csr_r[0] <= reg_wdata;
      end
      if (reg_addr == sfs_pkg::OFS_CSR1) begin
        csr_r[1] <= reg_wdata;
      end
      if (reg_addr == sfs_pkg::OFS_CSR2) begin
        csr_r[2] <= reg_wdata;
      end
      if (reg_addr == sfs_pkg::OFS_CSR3) begin
        csr_r[3] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      enabled_r <= 1'b0;
    end else if (dis_cmd || mode_fault_flag_ev) begin
      enabled_r <= 1'b0;  // see (RL5)
    end else if (en_cmd) begin
      enabled_r <= 1'b1;  // see (RL5)
    end
  end

  // mode fault and overrun: hardware set wins over the read clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_fault_flag_r <= 1'b0;
      ovr_r  <= 1'b0;
    end else begin
      if (mode_fault_flag_ev) begin
        mode_fault_flag_r <= 1'b1;  // see (RL4)
      end else if (sr_rd) begin
        mode_fault_flag_r <= 1'b0;  // see (RL4)
      end
      if (word_done && rx_full_r && !rdr_rd) begin
        ovr_r <= 1'b1;  // see (RL11)
      end else if (sr_rd) begin
        ovr_r <= 1'b0;  // see (RL11)
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_full_r <= 1'b0;
      rx_data_r <= '0;
    end else if (word_done) begin
      rx_full_r <= 1'b1;  // see (RL8)
      rx_data_r <= {cs_r, rx_sh_r[14:0], samp_bit};  // see (RL1)
    end else if (rdr_rd) begin
      rx_full_r <= 1'b0;  // see (RL8)
    end
  end

  // a fresh write outranks a pop in the same cycle: that word is still waiting
  always_ff @(posedge clk) begin
    if (!resetn || dis_cmd || mode_fault_flag_ev || !enabled_r && !en_cmd) begin
      tx_empty_r <= 1'b0;  // see (RL10)
    end else if (en_cmd) begin
      tx_empty_r <= 1'b1;  // see (RL10)
    end else if (tdr_wr) begin
      tx_empty_r <= 1'b0;  // see (RL9)
    end else if (fifo_pop) begin
      tx_empty_r <= 1'b1;  // see (RL9)
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        sfs_pkg::OFS_MODE:    reg_rdata <= mode_r;
        sfs_pkg::OFS_RX_DATA: reg_rdata <= {12'h000, rx_data_r};
        sfs_pkg::OFS_CSR0:    reg_rdata <= csr_r[0];
        sfs_pkg::OFS_CSR1:    reg_rdata <= csr_r[1];
        sfs_pkg::OFS_CSR2:    reg_rdata <= csr_r[2];
        sfs_pkg::OFS_CSR3:    reg_rdata <= csr_r[3];
        sfs_pkg::OFS_STATUS: begin
          reg_rdata                       <= '0;
          reg_rdata[sfs_pkg::SR_RX_FULL]  <= rx_full_r;
          reg_rdata[sfs_pkg::SR_TX_EMPTY] <= tx_empty_r && !fifo_valid;
          reg_rdata[sfs_pkg::SR_MODE_FAULT_FLAG]     <= mode_fault_flag_r;
          reg_rdata[sfs_pkg::SR_OVR]      <= ovr_r;
          reg_rdata[sfs_pkg::SR_RX_DMA]   <= rx_dma_end;  // see (RL12)
          reg_rdata[sfs_pkg::SR_TX_DMA]   <= tx_dma_end;  // see (RL13)
          reg_rdata[sfs_pkg::SR_ENABLED]  <= enabled_r;  // see (RL14)
        end
        default:              reg_rdata <= '0;
      endcase
    end
  end

  // serial clock half period in system cycles, zero treated as one
  always_ff @(posedge clk) begin
    if (!resetn || state_r == SFS_IDLE) begin
      div_cnt_r <= '0;
    end else if (tick) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end
  assign tick = (div_cnt_r + 8'h01 >= mode_r[sfs_pkg::MODE_DIV_HI:sfs_pkg::MODE_DIV_LO]);

  assign pop_pcs  = mode_r[sfs_pkg::MODE_PS] ? fifo_data[sfs_pkg::PCS_HI:sfs_pkg::PCS_LO]
                                              : mode_r[sfs_pkg::PCS_HI:sfs_pkg::PCS_LO];  // see (RL15)
  assign fifo_pop = enabled_r && fifo_valid &&
                    (is_master ? (state_r == SFS_IDLE) : (ss_low && !slv_loaded_r));
  assign m_edge   = (state_r == SFS_SHIFT) && tick;
  assign m_lead   = (sck_r == clock_polarity_r);
  assign s_edge   = !is_master && enabled_r && ss_low && (sck_sync_r[2] != sck_sync_r[1]);
  assign s_lead   = (sck_sync_r[1] != clock_polarity_r);
  assign sample_ev = is_master ? (m_edge && (m_lead == clock_phase_inv_r)) : (s_edge && (s_lead == clock_phase_inv_r));
  assign shift_ev  = (is_master ? (m_edge && (m_lead != clock_phase_inv_r)) : (s_edge && (s_lead != clock_phase_inv_r)))
                     && (bit_cnt_r != 5'h00);
  assign samp_bit  = is_master ? miso_sync_r[1] : mosi_sync_r[1];
  assign word_done = sample_ev && (bit_cnt_r + 5'h01 == nbits_r);

  always_ff @(posedge clk) begin
    if (!resetn || !enabled_r || mode_fault_flag_ev) begin
      state_r <= SFS_IDLE;
      sck_r   <= 1'b0;
      cs_r    <= sfs_pkg::PCS_IDLE;  // see (RL2)
    end else if (is_master) begin
      unique case (state_r)
        SFS_IDLE: begin
          sck_r <= clock_polarity_r;
          cs_r  <= sfs_pkg::PCS_IDLE;  // see (RL2)
          if (fifo_pop) begin
            cs_r    <= pcs_lines(pop_pcs, mode_r[sfs_pkg::MODE_SELECT_DECODE_BIT]);  // see (RL16)
            state_r <= SFS_SETUP;
          end
        end
        SFS_SETUP: begin
          sck_r <= clock_polarity_r;
          if (tick) begin
            state_r <= SFS_SHIFT;
          end
        end
        SFS_SHIFT: begin
          if (tick) begin
            sck_r <= !sck_r;
          end
          if (word_done) begin
            state_r <= SFS_END;
          end
        end
        SFS_END: begin
          if (tick) begin
            sck_r   <= clock_polarity_r;
            cs_r    <= sfs_pkg::PCS_IDLE;  // see (RL2)
            state_r <= SFS_IDLE;
          end
        end
      endcase
    end else begin
      state_r <= SFS_IDLE;
      sck_r   <= 1'b0;
      cs_r    <= sfs_pkg::PCS_IDLE;
    end
  end

  // word setup at pop; slave reads select config zero only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      nbits_r <= sfs_pkg::BITS_BASE;
      clock_polarity_r  <= 1'b0;
      clock_phase_inv_r <= 1'b0;
    end else if (!is_master) begin
      nbits_r <= word_bits(csr_r[0]);  // see (RL7)
      clock_polarity_r  <= csr_r[0][sfs_pkg::CSR_CLOCK_POLARITY];  // see (RL7)
      clock_phase_inv_r <= csr_r[0][sfs_pkg::CSR_CLOCK_PHASE_INV];  // see (RL7)
    end else if (fifo_pop) begin
      nbits_r <= word_bits(csr_r[csr_index(pop_pcs, mode_r[sfs_pkg::MODE_SELECT_DECODE_BIT])]);
      clock_polarity_r  <= csr_r[csr_index(pop_pcs, mode_r[sfs_pkg::MODE_SELECT_DECODE_BIT])][sfs_pkg::CSR_CLOCK_POLARITY];
      clock_phase_inv_r <= csr_r[csr_index(pop_pcs, mode_r[sfs_pkg::MODE_SELECT_DECODE_BIT])][sfs_pkg::CSR_CLOCK_PHASE_INV];
    end
  end

  // slave framing: nothing moves until slave-select is low
  always_ff @(posedge clk) begin
    if (!resetn || !enabled_r || is_master || !ss_low) begin
      slv_loaded_r <= 1'b0;  // see (RL6)
    end else if (word_done) begin
      slv_loaded_r <= 1'b0;
    end else if (!slv_loaded_r) begin
      slv_loaded_r <= 1'b1;  // see (RL6)
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || !enabled_r || (!is_master && !ss_low)) begin
      bit_cnt_r <= '0;
      tx_sh_r   <= '0;
      rx_sh_r   <= '0;
    end else if (fifo_pop || (!is_master && !slv_loaded_r)) begin
      bit_cnt_r <= '0;
      tx_sh_r   <= fifo_pop ? fifo_data[sfs_pkg::WORD_W-1:0] : 16'h0000;
      rx_sh_r   <= '0;
    end else begin
      if (sample_ev) begin
        rx_sh_r   <= {rx_sh_r[14:0], samp_bit};
        bit_cnt_r <= word_done ? 5'h00 : bit_cnt_r + 5'h01;
      end
      if (shift_ev) begin
        tx_sh_r <= {tx_sh_r[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      miso_r <= 1'b0;
    end else begin
      miso_r <= msb_pick(tx_sh_r, nbits_r);
    end
  end

  assign spck_out          = sck_r;
  assign spck_oe           = enabled_r && is_master;
  assign mosi_out          = miso_r;
  assign mosi_oe           = enabled_r && is_master;
  assign miso_out          = miso_r;
  assign miso_oe           = enabled_r && !is_master && ss_low;  // see (RL6)
  assign periph_select_out = cs_r;
endmodule

// ### logic/sfs_pkg.sv
package sfs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int PCS_W  = 4;
  localparam int FIFO_W = WORD_W + PCS_W;
  localparam int FIFO_D = 16;

  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MODE    = 8'h04;
  localparam logic [7:0] OFS_RX_DATA = 8'h08;
  localparam logic [7:0] OFS_TX_DATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_CSR0    = 8'h30;
  localparam logic [7:0] OFS_CSR1    = 8'h34;
  localparam logic [7:0] OFS_CSR2    = 8'h38;
  localparam logic [7:0] OFS_CSR3    = 8'h3C;

  // control register, write only
  localparam int CTL_ENABLE  = 0;
  localparam int CTL_DISABLE = 1;

  // mode register
  localparam int MODE_MASTER = 0;
  localparam int MODE_PS     = 1;
  localparam int MODE_SELECT_DECODE_BIT = 2;
  localparam int MODE_DIV_LO = 8;
  localparam int MODE_DIV_HI = 15;
  localparam int PCS_LO      = 16;
  localparam int PCS_HI      = 19;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;

  // chip-select configuration registers
  localparam int CSR_CLOCK_POLARITY    = 0;
  localparam int CSR_CLOCK_PHASE_INV   = 1;
  localparam int CSR_BITS_LO = 4;
  localparam int CSR_BITS_HI = 7;
  localparam logic [31:0] CSR_RESET = 32'h0000_0000;
  localparam logic [4:0]  BITS_BASE = 5'h08;
  localparam logic [3:0]  BITS_MAX  = 4'h8;

  // status register
  localparam int SR_RX_FULL  = 0;
  localparam int SR_TX_EMPTY = 1;
  localparam int SR_MODE_FAULT_FLAG     = 2;
  localparam int SR_OVR      = 3;
  localparam int SR_RX_DMA   = 4;
  localparam int SR_TX_DMA   = 5;
  localparam int SR_ENABLED  = 16;

  localparam logic [3:0] PCS_IDLE = 4'hF;
endpackage

// ### bench/sfs_top_monitor.sv
`timescale 1ns/1ns
module sfs_top_monitor (
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire logic [sfs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sfs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [sfs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       rx_dma_end,
  input wire logic                       tx_dma_end,
  input wire logic                       spck_oe,
  input wire logic                       miso_oe,
  input wire logic                       slave_select_in_n,
  input wire logic [sfs_pkg::PCS_W-1:0]  periph_select_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic st_rd;
  logic en_wr;
  assign st_rd = reg_rd && (reg_addr == sfs_pkg::OFS_STATUS);
  // a mode write may turn master pins on legally, so it is excused too
  assign en_wr = reg_wr && ((reg_addr == sfs_pkg::OFS_MODE)
    || ((reg_addr == sfs_pkg::OFS_CONTROL) && reg_wdata[sfs_pkg::CTL_ENABLE]));
  property p_cs_idle;
    !spck_oe && !$past(spck_oe) |-> periph_select_out == sfs_pkg::PCS_IDLE;
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("select low while idle");
  property p_cs_step;
    $changed(periph_select_out) |-> (periph_select_out == sfs_pkg::PCS_IDLE)
      || ($past(periph_select_out) == sfs_pkg::PCS_IDLE);
  endproperty
  a_cs_step: assert property (p_cs_step)
    else $error("select moved without going idle");
  property p_fault;
    spck_oe && !slave_select_in_n ##1 !slave_select_in_n [*2] |-> ##[0:2] !spck_oe;
  endproperty
  a_fault: assert property (p_fault)
    else $error("master kept driving under outside select");
  property p_stay_off;
    !spck_oe && !en_wr |=> !spck_oe;
  endproperty
  a_stay_off: assert property (p_stay_off)
    else $error("master pins on without enable");
  property p_slave_quiet;
    $past(slave_select_in_n, 2) && $past(slave_select_in_n, 3) |-> !miso_oe;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("slave drives while unselected");
  property p_rx_dma;
    $past(st_rd) |-> reg_rdata[sfs_pkg::SR_RX_DMA] == $past(rx_dma_end);
  endproperty
  a_rx_dma: assert property (p_rx_dma)
    else $error("rx dma bit wrong");
  property p_tx_dma;
    $past(st_rd) |-> reg_rdata[sfs_pkg::SR_TX_DMA] == $past(tx_dma_end);
  endproperty
  a_tx_dma: assert property (p_tx_dma)
    else $error("tx dma bit wrong");
  property p_enabled;
    $past(st_rd) && $past(spck_oe) |-> reg_rdata[sfs_pkg::SR_ENABLED];
  endproperty
  a_enabled: assert property (p_enabled)
    else $error("enabled bit low while master drives");
  c_fault: cover property (spck_oe && !slave_select_in_n);
  c_word: cover property ($fell(periph_select_out[0]));
  c_slave: cover property (miso_oe);
endmodule

// ### bench/sfs_spi_partner.sv
`timescale 1ns/1ns
module sfs_spi_partner (
  input  wire logic       spck_out,
  input  wire logic       mosi_out,
  input  wire logic       miso_out,
  input  wire logic       miso_oe,
  input  wire logic [3:0] periph_select_out,
  output logic            miso_in,
  output logic            spck_in,
  output logic            mosi_in,
  output logic            slave_select_in_n
);
  logic [7:0] sr_r = 8'h3C;
  logic [7:0] got_r = 8'h00;
  logic       out_r = 1'b0;
  int         words_r = 0;
  wire logic  sel = (periph_select_out != 4'hF);
  initial begin
    spck_in = 1'b0;
    mosi_in = 1'b0;
    slave_select_in_n = 1'b1;
  end
  // slave: plain shift loop, each word answers with the one before
  always @(posedge sel) begin
    out_r = sr_r[7];
    words_r++;
  end
  always @(posedge spck_out) if (sel) sr_r = {sr_r[6:0], mosi_out};
  always @(negedge spck_out) if (sel) out_r = sr_r[7];
  // released line shows the inverse, never a stale level
  assign miso_in = sel ? out_r : ~out_r;
  task automatic drive_select(input logic v);
    #3 slave_select_in_n = v;
  endtask
  // outside master; samples late in the high phase since the slave
  // answers through its synchroniser
  task automatic xfer(input logic [7:0] tx, input logic frame);
    #3 slave_select_in_n = !frame;
    #200;
    for (int i = 7; i >= 0; i--) begin
      mosi_in = tx[i];
      #40 spck_in = 1'b1;
      #36 got_r = {got_r[6:0], miso_oe ? miso_out : ~got_r[0]};
      #4 spck_in = 1'b0;
    end
    #200 slave_select_in_n = 1'b1;
    #200;
  endtask
endmodule

// ### bench/sfs_top_tb.sv
`timescale 1ns/1ns
module sfs_top_tb;
  logic        clk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        tx_ready;
  logic        rx_dma_end;
  logic        tx_dma_end;
  logic        spck_in, spck_out, spck_oe, mosi_in, mosi_out, mosi_oe;
  logic        miso_in, miso_out, miso_oe, slave_select_in_n;
  logic [3:0]  periph_select_out;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  integer      seed = 32'h2252507C;
  logic [63:0] exp_q[$];
  logic [63:0] note;
  logic        rd_d = 1'b0;
  logic [7:0]  prev;
  logic [7:0]  b;
  logic [31:0] cfg [2] = '{32'h000D_0401, 32'h0005_0405};

  sfs_top DUT (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_ready(tx_ready),
    .rx_dma_end(rx_dma_end), .tx_dma_end(tx_dma_end), .spck_in(spck_in),
    .spck_out(spck_out), .spck_oe(spck_oe), .mosi_in(mosi_in), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe),
    .slave_select_in_n(slave_select_in_n), .periph_select_out(periph_select_out)
  );
  sfs_spi_partner u_par (
    .spck_out(spck_out), .mosi_out(mosi_out), .miso_out(miso_out), .miso_oe(miso_oe),
    .periph_select_out(periph_select_out), .miso_in(miso_in), .spck_in(spck_in),
    .mosi_in(mosi_in), .slave_select_in_n(slave_select_in_n)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // strobe drops for a cycle between accesses, trading speed for clean drive
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e & m});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_words(input int n);
    for (int k = 0; k < 3000 && !(u_par.words_r == n && periph_select_out === 4'hF); k++) begin
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1) begin
      note = exp_q.pop_front();
      check(reg_rdata & note[63:32], note[31:0]);
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rx_dma_end = 1'b0;
    tx_dma_end = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(sfs_pkg::OFS_STATUS, 32'h0, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) begin
      {rx_dma_end, tx_dma_end} <= 2'($random(seed));
      @(posedge clk);
      rd(sfs_pkg::OFS_STATUS, {26'h0, tx_dma_end, rx_dma_end, 4'h0}, 32'h30);
    end
    $display("test reset and dma done");
    wr(sfs_pkg::OFS_MODE, 32'h000E_0403);
    for (int i = 0; i < 4; i++) begin
      wr(sfs_pkg::OFS_CSR0 + 8'(4 * i), 32'h2);
    end
    for (int i = 0; i < 16; i++) begin
      check({31'h0, tx_ready}, 32'h1);
      prev = b;
      b = 8'($random(seed));
      wr(sfs_pkg::OFS_TX_DATA, {12'h0, 4'hE, 8'h0, b});
    end
    check({31'h0, tx_ready}, 32'h0);
    wr(sfs_pkg::OFS_TX_DATA, 32'h0000_00FF);
    rd(sfs_pkg::OFS_STATUS, 32'h0, 32'h1_0002);
    wr(sfs_pkg::OFS_CONTROL, 32'h1);
    wait_words(16);
    check({24'h0, u_par.sr_r}, {24'h0, b});
    rd(sfs_pkg::OFS_STATUS, 32'h1_000B, 32'h1_000F);
    rd(sfs_pkg::OFS_STATUS, 32'h1_0003, 32'h1_000F);
    rd(sfs_pkg::OFS_RX_DATA, {12'h0, 4'hE, 8'h0, prev}, 32'h000F_00FF);
    rd(sfs_pkg::OFS_STATUS, 32'h1_0002, 32'h1_000F);
    $display("test master drain done");
    foreach (cfg[i]) begin
      wr(sfs_pkg::OFS_MODE, cfg[i]);
      prev = b;
      b = 8'($random(seed));
      wr(sfs_pkg::OFS_TX_DATA, {12'h0, 4'hE, 8'h0, b});
      wait_words(17 + i);
      rd(sfs_pkg::OFS_RX_DATA, {12'h0, cfg[i][19:16], 8'h0, prev}, 32'h000F_00FF);
    end
    $display("test select modes done");
    wr(sfs_pkg::OFS_MODE, 32'h0000_0401);
    u_par.drive_select(1'b0);
    repeat (6) @(posedge clk);
    rd(sfs_pkg::OFS_STATUS, 32'h4, 32'h1_0006);
    rd(sfs_pkg::OFS_STATUS, 32'h0, 32'h1_0006);
    u_par.drive_select(1'b1);
    repeat (4) @(posedge clk);
    rd(sfs_pkg::OFS_STATUS, 32'h0, 32'h1_0000);
    wr(sfs_pkg::OFS_CONTROL, 32'h1);
    rd(sfs_pkg::OFS_STATUS, 32'h1_0002, 32'h1_0006);
    $display("test mode fault done");
    wr(sfs_pkg::OFS_CONTROL, 32'h2);
    wr(sfs_pkg::OFS_MODE, 32'h0);
    wr(sfs_pkg::OFS_CSR1, 32'h81);
    wr(sfs_pkg::OFS_CONTROL, 32'h1);
    wr(sfs_pkg::OFS_TX_DATA, 32'hA5);
    u_par.xfer(8'h77, 1'b0);
    @(posedge clk);
    rd(sfs_pkg::OFS_STATUS, 32'h0, 32'h1);
    u_par.xfer(8'h5A, 1'b1);
    check({24'h0, u_par.got_r}, 32'hA5);
    u_par.xfer(8'hC3, 1'b1);
    check({24'h0, u_par.got_r}, 32'h0);
    @(posedge clk);
    rd(sfs_pkg::OFS_STATUS, 32'h1_000B, 32'h1_000F);
    rd(sfs_pkg::OFS_RX_DATA, 32'hC3, 32'hFF);
    @(posedge clk);
    $display("test slave mode done");
    end_of_test();
  end
endmodule

bind sfs_top sfs_top_monitor u_mon (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_dma_end(rx_dma_end),
  .tx_dma_end(tx_dma_end), .spck_oe(spck_oe), .miso_oe(miso_oe),
  .slave_select_in_n(slave_select_in_n), .periph_select_out(periph_select_out)
);
